// file: rtl/ctsa_consts.svh
// register offsets, field positions and reset values of the tx select / abort / filter block
`ifndef CTSA_CONSTS_SVH
`define CTSA_CONSTS_SVH

`define CTSA_ADDR_W         4
`define CTSA_OFF_ABORT_ACK  4'h0
`define CTSA_OFF_TX_SEL     4'h1
`define CTSA_OFF_FILT_CTRL  4'h2
`define CTSA_OFF_MODE       4'h3
`define CTSA_OFF_TX_FLAGS   4'h4
`define CTSA_OFF_ABORT_REQ  4'h5
`define CTSA_OFF_IRQ_STAT   4'h6
`define CTSA_OFF_IRQ_MASK   4'h7

`define CTSA_FORG_LSB       4
`define CTSA_FORG_MSB       5
`define CTSA_HIT_LSB        0
`define CTSA_HIT_MSB        2

`define CTSA_MODE_INIT_REQUEST    0
`define CTSA_MODE_INIT_ACKNOWLEDGE    1

`define CTSA_IRQ_ABORT      0
`define CTSA_IRQ_SENT       1
`define CTSA_IRQ_RXLOAD     2

`define CTSA_RST_SLOTS      3'h0
`define CTSA_RST_EMPTY      3'h7
`define CTSA_RST_FORG       2'h0
`define CTSA_RST_HIT        3'h0
`define CTSA_RST_IRQ        3'h0

`endif

// file: rtl/ctsa_pkg.sv
// types shared by the tx select / abort / filter block
package ctsa_pkg;

  typedef enum logic [1:0] {
    CTSA_ORG_2X32,
    CTSA_ORG_4X16,
    CTSA_ORG_8X8,
    CTSA_ORG_CLOSED
  } ctsa_forg_t;

  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ctsa_bus_req_t;

  // shared transmit window access from the cpu side
  typedef struct packed {
    logic       rd;
    logic       wr;
  } ctsa_win_req_t;

  // protocol engine report, one bit per transmit slot
  typedef struct packed {
    logic [2:0] sent;
    logic [2:0] aborted;
  } ctsa_tx_evt_t;

  // receive fifo shift into foreground buffer
  typedef struct packed {
    logic       shift;
    logic [2:0] hit;
  } ctsa_rx_evt_t;

endpackage

// file: rtl/ctsa_lowest_sel.sv
// isolates the lowest set bit of a select vector and encodes its index
`timescale 1ns/1ps
module ctsa_lowest_sel #(
  parameter int N = 3
) (
  // select vector
  input  wire logic [N-1:0]         vec_in,
  // lowest bit only, index and any-set
  output logic      [N-1:0]         onehot_out,
  output logic      [$clog2(N)-1:0] index_out,
  output logic                      any_out
);

  logic [N:0] seen;

  assign seen[0] = 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_low
      assign onehot_out[gi] = vec_in[gi] & ~seen[gi];
      assign seen[gi+1]     = seen[gi] | vec_in[gi];
    end
  endgenerate

  always_comb begin
    index_out = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (vec_in[i]) begin
        index_out = i[$clog2(N)-1:0];
      end
    end
  end

  assign any_out = seen[N];

endmodule

// file: rtl/ctsa_ctrl.sv
// tx slot selector, abort acknowledge flags and acceptance filter control
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "ctsa_consts.svh"

module ctsa_ctrl #(
  parameter int SLOTS = 3
) (
  // clock and reset
  input  wire logic                      clk_sys_in,
  input  wire logic                      rstn_in,
  // register port
  input  wire ctsa_pkg::ctsa_bus_req_t   bus_in,
  output logic      [7:0]                rdata_out,
  // init handshake with the protocol engine
  input  wire logic                      init_acknowledge_in,
  output logic                           init_request_out,
  // shared transmit window
  input  wire ctsa_pkg::ctsa_win_req_t   win_in,
  output logic                           win_grant_out,
  output logic      [1:0]                win_slot_out,
  // protocol engine transmit side
  input  wire ctsa_pkg::ctsa_tx_evt_t    tx_evt_in,
  input  wire logic [SLOTS-1:0]          tx_started_in,
  output logic      [SLOTS-1:0]          transmit_slot_empty_out,
  output logic      [SLOTS-1:0]          abort_request_bit_out,
  // receive side
  input  wire ctsa_pkg::ctsa_rx_evt_t    rx_evt_in,
  output logic                           rx_load_out,
  output ctsa_pkg::ctsa_forg_t           filter_organisation_out,
  // interrupt
  output logic                           irq_out
);
  import ctsa_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [SLOTS-1:0] abort_ack_reg;
  logic [SLOTS-1:0] tx_sel_reg;
  logic [SLOTS-1:0] empty_reg;
  logic [SLOTS-1:0] abort_req_reg;
  ctsa_forg_t       forg_reg;
  logic [2:0]       hit_reg;
  logic             init_rq_reg;
  logic [2:0]       irq_stat_reg;
  logic [2:0]       irq_mask_reg;
  logic [7:0]       rdata_reg;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  logic [SLOTS-1:0] abort_ack_next;
  logic [SLOTS-1:0] tx_sel_next;
  logic [SLOTS-1:0] empty_next;
  logic [SLOTS-1:0] abort_req_next;
  ctsa_forg_t       forg_next;
  logic [2:0]       hit_next;
  logic             init_rq_next;
  logic [2:0]       irq_stat_next;
  logic [2:0]       irq_mask_next;
  logic [7:0]       rdata_next;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic             init_mode;
  logic             run_mode;
  logic             wr_sel;
  logic             wr_filt;
  logic             wr_mode;
  logic             wr_empty;
  logic             wr_areq;
  logic             wr_istat;
  logic             wr_imask;
  logic [SLOTS-1:0] sel_onehot;
  logic [1:0]       sel_index;
  logic             sel_any;
  logic [SLOTS-1:0] empty_clr;
  logic [SLOTS-1:0] empty_set;
  logic [SLOTS-1:0] abort_grant;
  logic             rx_accept;
  logic [SLOTS-1:0] sent_evt;
  logic [SLOTS-1:0] abort_pending;
  logic             sel_free;
  logic             win_req;

  // both bits high is init; both low is normal; mixed states are in transit
  assign init_mode = init_rq_reg & init_acknowledge_in;
  assign run_mode  = ~init_rq_reg & ~init_acknowledge_in;

  // strobes are one cycle wide, so decodes need no edge detection
  assign wr_sel   = bus_in.wr && bus_in.addr == `CTSA_OFF_TX_SEL;
  assign wr_filt  = bus_in.wr && bus_in.addr == `CTSA_OFF_FILT_CTRL;
  assign wr_mode  = bus_in.wr && bus_in.addr == `CTSA_OFF_MODE;
  assign wr_empty = bus_in.wr && bus_in.addr == `CTSA_OFF_TX_FLAGS;
  assign wr_areq  = bus_in.wr && bus_in.addr == `CTSA_OFF_ABORT_REQ;
  assign wr_istat = bus_in.wr && bus_in.addr == `CTSA_OFF_IRQ_STAT;
  assign wr_imask = bus_in.wr && bus_in.addr == `CTSA_OFF_IRQ_MASK;

  ctsa_lowest_sel #(
    .N (SLOTS)
  ) u_low (
    .vec_in     (tx_sel_reg),
    .onehot_out (sel_onehot),
    .index_out  (sel_index),
    .any_out    (sel_any)
  );

  // ----------------------------------------------------------------
  // transmit slots
  // ----------------------------------------------------------------
  // a success report on an already empty slot is stale and must not touch it
  assign sent_evt      = tx_evt_in.sent & ~empty_reg;
  assign abort_pending = abort_req_reg & ~empty_reg;

  // grant only when still pending and not started, or the engine reports
  // the attempt failed (aborted event with request pending)
  assign abort_grant = abort_pending & (~tx_started_in | tx_evt_in.aborted);

  // cpu clears empty by writing one to it, mirroring a scheduling request
  assign empty_clr = (wr_empty && run_mode) ? bus_in.wdata[SLOTS-1:0] & empty_reg
                                            : '0;
  assign empty_set = sent_evt | abort_grant;

  always_comb begin
    empty_next     = empty_reg;
    abort_ack_next = abort_ack_reg;
    abort_req_next = abort_req_reg;
    for (int i = 0; i < SLOTS; i++) begin
      if (empty_set[i]) begin
        empty_next[i]     = 1'b1;
        abort_req_next[i] = 1'b0;
        if (abort_grant[i]) begin
          abort_ack_next[i] = 1'b1;
        end else begin
          abort_ack_next[i] = 1'b0;
        end
      end else if (empty_clr[i]) begin
        empty_next[i]     = 1'b0;
        abort_ack_next[i] = 1'b0;
      end
      // request accepted only for scheduled slots; writing zero never clears
      if (wr_areq && run_mode && bus_in.wdata[i] && !empty_reg[i] && !empty_set[i]) begin
        abort_req_next[i] = 1'b1;
      end
    end
    // init wins over any same-cycle event on ack and request bits; empty flags still take the event; the engine is frozen then anyway
    if (init_mode) begin
      abort_ack_next = `CTSA_RST_SLOTS;
      abort_req_next = `CTSA_RST_SLOTS;
    end
  end

  // flags come up empty so no slot looks scheduled after reset
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      empty_reg     <= `CTSA_RST_EMPTY;
      abort_ack_reg <= `CTSA_RST_SLOTS;
      abort_req_reg <= `CTSA_RST_SLOTS;
    end else begin
      empty_reg     <= empty_next;
      abort_ack_reg <= abort_ack_next;
      abort_req_reg <= abort_req_next;
    end
  end

  // ----------------------------------------------------------------
  // selector and shared window
  // ----------------------------------------------------------------
  always_comb begin
    tx_sel_next = tx_sel_reg;
    if (init_mode) begin
      tx_sel_next = `CTSA_RST_SLOTS;
    // writes during the mixed init states are dropped, not deferred
    end else if (wr_sel && run_mode) begin
      tx_sel_next = bus_in.wdata[SLOTS-1:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      tx_sel_reg <= `CTSA_RST_SLOTS;
    end else begin
      tx_sel_reg <= tx_sel_next;
    end
  end

  // a scheduled slot belongs to the engine; touching it would corrupt the frame
  assign win_req       = win_in.rd | win_in.wr;
  assign sel_free      = |(sel_onehot & empty_reg);
  assign win_slot_out  = sel_index;
  assign win_grant_out = win_req & sel_any & sel_free;

  // ----------------------------------------------------------------
  // acceptance filter control
  // ----------------------------------------------------------------
  // hit index moves only with an accepted shift, so it names the foreground message
  assign rx_accept = rx_evt_in.shift && forg_reg != CTSA_ORG_CLOSED;

  always_comb begin
    forg_next = forg_reg;
    hit_next  = hit_reg;
    if (wr_filt && init_mode) begin
      forg_next = ctsa_forg_t'(bus_in.wdata[`CTSA_FORG_MSB:`CTSA_FORG_LSB]);
    end
    if (rx_accept) begin
      hit_next = rx_evt_in.hit;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      forg_reg <= ctsa_forg_t'(`CTSA_RST_FORG);
      hit_reg  <= `CTSA_RST_HIT;
    end else begin
      forg_reg <= forg_next;
      hit_reg  <= hit_next;
    end
  end

  assign rx_load_out             = rx_accept;
  assign filter_organisation_out = forg_reg;

  // ----------------------------------------------------------------
  // mode and interrupts
  // ----------------------------------------------------------------
  always_comb begin
    init_rq_next  = init_rq_reg;
    irq_stat_next = irq_stat_reg;
    irq_mask_next = irq_mask_reg;
    // no ack check here: the engine owns the handshake timing
    if (wr_mode) begin
      init_rq_next = bus_in.wdata[`CTSA_MODE_INIT_REQUEST];
    end
    if (wr_imask) begin
      irq_mask_next = bus_in.wdata[2:0];
    end
    if (wr_istat) begin
      irq_stat_next = irq_stat_reg & ~bus_in.wdata[2:0];
    end
    // events after the clear so a same-cycle set wins
    if (|abort_grant) begin
      irq_stat_next[`CTSA_IRQ_ABORT] = 1'b1;
    end
    if (|sent_evt) begin
      irq_stat_next[`CTSA_IRQ_SENT] = 1'b1;
    end
    if (rx_accept) begin
      irq_stat_next[`CTSA_IRQ_RXLOAD] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      init_rq_reg  <= 1'b0;
      irq_stat_reg <= `CTSA_RST_IRQ;
      irq_mask_reg <= `CTSA_RST_IRQ;
    end else begin
      init_rq_reg  <= init_rq_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  assign init_request_out        = init_rq_reg;
  // level output; software drops it by writing ones to the status word
  assign irq_out                 = |(irq_stat_reg & irq_mask_reg);
  assign transmit_slot_empty_out = empty_reg;
  assign abort_request_bit_out   = abort_req_reg;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        `CTSA_OFF_ABORT_ACK: begin
          rdata_next[SLOTS-1:0] = abort_ack_reg;
        end
        `CTSA_OFF_TX_SEL: begin
          rdata_next[SLOTS-1:0] = sel_onehot;
        end
        `CTSA_OFF_FILT_CTRL: begin
          rdata_next[`CTSA_FORG_MSB:`CTSA_FORG_LSB] = forg_reg;
          rdata_next[`CTSA_HIT_MSB:`CTSA_HIT_LSB]   = hit_reg;
        end
        `CTSA_OFF_MODE: begin
          rdata_next[`CTSA_MODE_INIT_REQUEST] = init_rq_reg;
          rdata_next[`CTSA_MODE_INIT_ACKNOWLEDGE] = init_acknowledge_in;
        end
        `CTSA_OFF_TX_FLAGS: begin
          rdata_next[SLOTS-1:0] = empty_reg;
        end
        `CTSA_OFF_ABORT_REQ: begin
          rdata_next[SLOTS-1:0] = abort_req_reg;
        end
        `CTSA_OFF_IRQ_STAT: begin
          rdata_next[2:0] = irq_stat_reg;
        end
        `CTSA_OFF_IRQ_MASK: begin
          rdata_next[2:0] = irq_mask_reg;
        end
        // unmapped offsets read as zero; there is no bus error path
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // registered so read data stand exactly one cycle after the strobe
  assign rdata_out = rdata_reg;

endmodule

// file: verification/ctsa_ctrl_props.sv
// concurrent checks on the tx select / abort / filter control block
`timescale 1ns/1ps
`include "ctsa_consts.svh"
module ctsa_ctrl_props
  import ctsa_pkg::*;
#(
  parameter int SLOTS = 3
) (
  // clock and reset
  input wire logic              clk_sys_in,
  input wire logic              rstn_in,
  // register port
  input wire ctsa_bus_req_t     bus_in,
  input wire logic [7:0]        rdata_out,
  // init, window, tx, rx
  input wire logic              init_acknowledge_in,
  input wire logic              init_request_out,
  input wire ctsa_win_req_t     win_in,
  input wire logic              win_grant_out,
  input wire logic [1:0]        win_slot_out,
  input wire ctsa_tx_evt_t      tx_evt_in,
  input wire logic [SLOTS-1:0]  tx_started_in,
  input wire logic [SLOTS-1:0]  transmit_slot_empty_out,
  input wire logic [SLOTS-1:0]  abort_request_bit_out,
  input wire ctsa_rx_evt_t      rx_evt_in,
  input wire logic              rx_load_out,
  input wire ctsa_forg_t        filter_organisation_out
);
  logic             init_mode;
  logic [SLOTS-1:0] grant_v;
  assign init_mode = init_request_out && init_acknowledge_in;
  assign grant_v = abort_request_bit_out & ~transmit_slot_empty_out
                   & (~tx_started_in | tx_evt_in.aborted);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);
  sequence s_abort_granted;
    grant_v != '0;
  endsequence
  sequence s_slot_emptied;
    ((transmit_slot_empty_out & $past(grant_v)) == $past(grant_v))
      && ((abort_request_bit_out & $past(grant_v)) == '0);
  endsequence
  a_abort_grant_empties: assert property (s_abort_granted |=> s_slot_emptied)
    else $error("granted abort did not empty the slot");
  a_empty_drops_req: assert property ((transmit_slot_empty_out
    & ~$past(transmit_slot_empty_out) & abort_request_bit_out) == '0)
    else $error("abort request survived empty flag");
  a_init_ack_zero: assert property (init_mode && $past(init_mode) && bus_in.rd
    && bus_in.addr == `CTSA_OFF_ABORT_ACK |=> rdata_out == 8'h00)
    else $error("abort ack not held in reset during init");
  a_sel_lowest_only: assert property (bus_in.rd && bus_in.addr == `CTSA_OFF_TX_SEL
    |=> $onehot0(rdata_out) && rdata_out[7:3] == 5'h00)
    else $error("selector read shows more than one bit");
  a_init_no_select: assert property (init_mode && $past(init_mode)
    |-> win_slot_out == 2'h0 && !win_grant_out)
    else $error("selector not reset during init");
  a_grant_needs_empty: assert property (win_grant_out
    |-> transmit_slot_empty_out[win_slot_out] && (win_in.rd || win_in.wr))
    else $error("window granted on scheduled slot");
  a_closed_no_load: assert property (filter_organisation_out == CTSA_ORG_CLOSED
    |-> !rx_load_out)
    else $error("closed filter loaded a message");
  a_load_on_shift: assert property (rx_evt_in.shift
    && filter_organisation_out != CTSA_ORG_CLOSED |-> rx_load_out)
    else $error("accepted shift did not load");
endmodule
bind ctsa_ctrl ctsa_ctrl_props #(.SLOTS(SLOTS)) u_props (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .bus_in(bus_in), .rdata_out(rdata_out),
  .init_acknowledge_in(init_acknowledge_in), .init_request_out(init_request_out),
  .win_in(win_in), .win_grant_out(win_grant_out), .win_slot_out(win_slot_out),
  .tx_evt_in(tx_evt_in), .tx_started_in(tx_started_in),
  .transmit_slot_empty_out(transmit_slot_empty_out),
  .abort_request_bit_out(abort_request_bit_out), .rx_evt_in(rx_evt_in),
  .rx_load_out(rx_load_out), .filter_organisation_out(filter_organisation_out));

// file: verification/ctsa_can_peer.sv
// protocol engine and bus peer model driving the block's engine side
`timescale 1ns/1ps
module ctsa_can_peer
  import ctsa_pkg::*;
(
  // clock and reset
  input  wire logic      clk_sys_in,
  input  wire logic      rstn_in,
  // init handshake
  input  wire logic      init_request_in,
  output logic           init_acknowledge_out,
  // engine reports
  output ctsa_tx_evt_t   tx_evt_out,
  output logic [2:0]     tx_started_out,
  output ctsa_rx_evt_t   rx_evt_out
);
  logic [1:0] ack_pipe_reg;
  initial begin
    tx_evt_out = '0;
    tx_started_out = 3'h0;
    rx_evt_out = '0;
  end
  // ack lags the request so init mode is never entered instantly
  always_ff @(posedge clk_sys_in) begin
    ack_pipe_reg <= rstn_in ? {ack_pipe_reg[0], init_request_in} : 2'h0;
  end
  assign init_acknowledge_out = ack_pipe_reg[1];
  task automatic start(input logic [2:0] s);
    @(posedge clk_sys_in);
    tx_started_out <= s;
  endtask
  task automatic evt(input logic [2:0] sent, input logic [2:0] abt,
                     input logic sh, input logic [2:0] hit);
    @(posedge clk_sys_in);
    tx_evt_out <= '{sent, abt};
    rx_evt_out <= '{sh, hit};
    tx_started_out <= tx_started_out & ~abt;
    @(posedge clk_sys_in);
    tx_evt_out <= '0;
    rx_evt_out <= '0;
  endtask
endmodule

// file: verification/tb.sv
// self-checking bench for the tx select / abort / filter control block
`timescale 1ns/1ps
`include "ctsa_consts.svh"
module tb;
  import ctsa_pkg::*;
  logic          clk_sys_in = 1'b0;
  logic          rstn_in = 1'b0;
  ctsa_bus_req_t bus = '0;
  ctsa_win_req_t win = '0;
  logic [7:0]    rdata;
  logic          init_req, init_ack, grant, rx_load, irq;
  logic [1:0]    slot;
  logic [2:0]    empty, areq, started;
  ctsa_tx_evt_t  tx_evt;
  ctsa_rx_evt_t  rx_evt;
  ctsa_forg_t    org;
  int            bad_count = 0;
  int            total_checks = 0;
  // {write, addr, wdata, expected read}
  localparam logic [20:0] ROWS [9] = '{
    {1'b0, `CTSA_OFF_ABORT_ACK, 8'h00, 8'h00}, {1'b0, `CTSA_OFF_TX_FLAGS, 8'h00, 8'h07},
    {1'b1, `CTSA_OFF_TX_SEL, 8'h03, 8'h00}, {1'b0, `CTSA_OFF_TX_SEL, 8'h00, 8'h01},
    {1'b1, `CTSA_OFF_ABORT_ACK, 8'hFF, 8'h00}, {1'b0, `CTSA_OFF_ABORT_ACK, 8'h00, 8'h00},
    {1'b1, `CTSA_OFF_FILT_CTRL, 8'h30, 8'h00}, {1'b0, `CTSA_OFF_FILT_CTRL, 8'h00, 8'h00},
    {1'b0, 4'h9, 8'h00, 8'h00}};
  always #25 clk_sys_in = ~clk_sys_in;
  ctsa_ctrl #(.SLOTS(3)) DUT (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .bus_in(bus),
    .rdata_out(rdata), .init_acknowledge_in(init_ack), .init_request_out(init_req),
    .win_in(win), .win_grant_out(grant), .win_slot_out(slot), .tx_evt_in(tx_evt),
    .tx_started_in(started), .transmit_slot_empty_out(empty), .abort_request_bit_out(areq),
    .rx_evt_in(rx_evt), .rx_load_out(rx_load), .filter_organisation_out(org), .irq_out(irq));
  ctsa_can_peer peer (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .init_request_in(init_req),
    .init_acknowledge_out(init_ack), .tx_evt_out(tx_evt), .tx_started_out(started),
    .rx_evt_out(rx_evt));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus_op(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    bus <= '{a, d, w, ~w};
    @(posedge clk_sys_in);
    bus <= '0;
    #1;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    bus_op(1'b0, a, 8'h00);
    chk(rdata, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    foreach (ROWS[i]) begin
      bus_op(ROWS[i][20], ROWS[i][19:16], ROWS[i][15:8]);
      if (!ROWS[i][20]) chk(rdata, ROWS[i][7:0]);
    end
    bus_op(1'b1, `CTSA_OFF_IRQ_MASK, 8'h01);
    bus_op(1'b1, `CTSA_OFF_TX_FLAGS, 8'h01);
    bus_op(1'b1, `CTSA_OFF_ABORT_REQ, 8'h01);
    cyc(3);
    chk({2'h0, empty, areq}, 8'h38);
    rd_chk(`CTSA_OFF_ABORT_ACK, 8'h01);
    chk({7'h00, irq}, 8'h01);
    bus_op(1'b1, `CTSA_OFF_IRQ_STAT, 8'h07);
    chk({7'h00, irq}, 8'h00);
    bus_op(1'b1, `CTSA_OFF_TX_FLAGS, 8'h01);
    rd_chk(`CTSA_OFF_ABORT_ACK, 8'h00);
    // slot 1 sent normally, slot 2 aborted only after a failed attempt
    bus_op(1'b1, `CTSA_OFF_TX_FLAGS, 8'h02);
    peer.evt(3'h2, 3'h0, 1'b0, 3'h0);
    rd_chk(`CTSA_OFF_ABORT_ACK, 8'h00);
    peer.start(3'h4);
    bus_op(1'b1, `CTSA_OFF_TX_FLAGS, 8'h04);
    bus_op(1'b1, `CTSA_OFF_ABORT_REQ, 8'h04);
    cyc(3);
    chk({2'h0, empty, areq}, 8'h14);
    peer.evt(3'h0, 3'h4, 1'b0, 3'h0);
    rd_chk(`CTSA_OFF_ABORT_ACK, 8'h04);
    chk({7'h00, irq}, 8'h01);
    bus_op(1'b1, `CTSA_OFF_IRQ_MASK, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rd_chk(`CTSA_OFF_TX_FLAGS, 8'h06);
    bus_op(1'b1, `CTSA_OFF_TX_SEL, rdata);
    rd_chk(`CTSA_OFF_TX_SEL, 8'h02);
    @(posedge clk_sys_in);
    win <= '{1'b1, 1'b0};
    cyc(1);
    chk({5'h00, grant, slot}, 8'h05);
    bus_op(1'b1, `CTSA_OFF_TX_SEL, 8'h03);
    chk({5'h00, grant, slot}, 8'h00);
    bus_op(1'b1, `CTSA_OFF_TX_SEL, 8'h00);
    chk({5'h00, grant, slot}, 8'h00);
    bus_op(1'b1, `CTSA_OFF_MODE, 8'h01);
    cyc(4);
    rd_chk(`CTSA_OFF_ABORT_ACK, 8'h00);
    bus_op(1'b1, `CTSA_OFF_TX_SEL, 8'h01);
    rd_chk(`CTSA_OFF_TX_SEL, 8'h00);
    for (int k = 0; k < 4; k++) begin
      bus_op(1'b1, `CTSA_OFF_FILT_CTRL, 8'(k << 4));
      rd_chk(`CTSA_OFF_FILT_CTRL, 8'(k << 4));
      chk({6'h00, org}, 8'(k));
    end
    bus_op(1'b1, `CTSA_OFF_FILT_CTRL, 8'h10);
    peer.evt(3'h0, 3'h0, 1'b1, 3'h5);
    rd_chk(`CTSA_OFF_FILT_CTRL, 8'h15);
    bus_op(1'b1, `CTSA_OFF_FILT_CTRL, 8'h30);
    peer.evt(3'h0, 3'h0, 1'b1, 3'h2);
    rd_chk(`CTSA_OFF_FILT_CTRL, 8'h35);
    @(posedge clk_sys_in);
    rstn_in <= 1'b0;
    cyc(2);
    @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    rd_chk(`CTSA_OFF_TX_FLAGS, 8'h07);
    rd_chk(`CTSA_OFF_FILT_CTRL, 8'h00);
    give_verdict();
  end
  // hang guard, well beyond the roughly 135 cycles the sequence needs
  initial begin
    repeat (2000) @(posedge clk_sys_in);
    bad_count++;
    give_verdict();
  end
endmodule
